// ==== rtl/cgr_regbank.sv ====
// Purpose: GPIO, status, misc, spatial and EQ window register bank
// Assumes: Avalon-MM slave, one wait state per access
// Notes: Pin and analog status inputs other than pen_status_in pass a two stage synchroniser
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cgr_defs.svh"
module cgr_regbank (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [8:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire cgr_pkg::cgr_thermal_s thermal_in,
    input wire cgr_pkg::cgr_virtual_s virtual_pin_source_in,
    input wire logic pen_status_in,
    input wire logic [13:1] sticky_enable_in,
    input wire logic [5:1] pin_is_input_in,
    input wire logic irq_request_in,
    input wire logic eq_enable_in,
    input wire logic [4:0] eq_overflow_in,
    input wire logic [5:1] gpio_pin_in,
    output logic [5:1] gpio_pin_out,
    output logic [5:1] gpio_pin_oe_out,
    input wire logic reset_pen_pin_in,
    output logic reset_pen_pin_out,
    output logic reset_pen_pin_oe_out,
    output logic codec_reset_request_out,
    output logic [19:0] slot12_status_out,
    output cgr_pkg::cgr_misc_s misc_out,
    output cgr_pkg::cgr_spatial_s spatial_out,
    output logic spatial_clear_out,
    output logic allpass_reset_out,
    output cgr_pkg::cgr_coef_t coef_out
);
    import cgr_pkg::*;

    function automatic logic hit(input logic [8:0] a, input logic [6:0] i);
        return a[8:2] == i;
    endfunction

    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        return {{8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [15:0] m);
        return (old & ~m) | (val & m);
    endfunction

    cgr_phase_e phase;
    cgr_phase_e next_phase;
    logic [31:0] next_readdata;
    logic [`CGR_SYNC_W-1:0] sync_a;
    logic [`CGR_SYNC_W-1:0] sync_b;
    logic [15:0] pin_share;
    logic [15:0] next_pin_share;
    logic [15:0] drive;
    logic [15:0] next_drive;
    cgr_misc_s next_misc;
    cgr_spatial_s next_spatial;
    logic [15:0] ind_addr;
    logic [15:0] next_ind_addr;
    cgr_coef_t next_coef;
    logic [15:0] eq_flags;
    logic [15:0] next_eq_flags;
    logic [15:0] latched;
    logic [15:0] next_latched;
    logic next_spatial_clear;
    logic next_allpass_reset;
    logic [5:1] next_pin_out;
    logic [5:1] next_pin_oe;
    logic next_rp_out;
    logic next_rp_oe;
    logic next_reset_req;
    logic [19:0] next_slot12;
    cgr_thermal_s thermal_sync;
    cgr_virtual_s virtual_sync;
    logic [15:0] live;
    logic [15:0] gpio_status;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic commit;
    logic ind_hit;
    logic irq_level;

    // Synchronised pin levels, second stage only
    assign thermal_sync = cgr_thermal_s'(sync_b[11:0]);
    assign virtual_sync = cgr_virtual_s'(sync_b[19:17]);
    assign wmask = lane_mask(byteenable_in);
    assign wdata = writedata_in[15:0];
    // Write lands at the edge the master sees waitrequest low
    assign commit = write_in && (phase == CGR_ANSWER);
    assign ind_hit = ind_addr[6:0] < `CGR_COEF_COUNT;
    assign irq_level = irq_request_in ^ misc_out.irq_invert;

    always_comb begin
        live = `CGR_RST_ZERO;
        live[5:1] = sync_b[16:12];
        live[9] = virtual_sync.mic_bias_supply_two_short;
        live[10] = virtual_sync.mic_bias_supply_one_short;
        live[11] = virtual_sync.overtemp;
        live[13] = pen_status_in;
        gpio_status = (live | latched) & `CGR_MASK_GPIO_STAT;
    end

    always_comb begin
        next_phase = CGR_IDLE;
        next_readdata = readdata_out;
        if ((read_in || write_in) && phase == CGR_IDLE) begin
            next_phase = CGR_ANSWER;
        end
        if (read_in && phase == CGR_IDLE) begin
            next_readdata = 32'h0000_0000;
            case (address_in[8:2])
                `CGR_IDX_GPIO_STAT: begin
                    next_readdata[15:0] = gpio_status;
                end
                `CGR_IDX_PIN_SHARE: begin
                    next_readdata[15:0] = pin_share;
                end
                `CGR_IDX_THERMAL: begin
                    next_readdata[15:0] = {4'h0, thermal_sync};
                end
                `CGR_IDX_DRIVE: begin
                    next_readdata[15:0] = drive;
                end
                `CGR_IDX_MISC: begin
                    next_readdata[15:0] = misc_out;
                end
                `CGR_IDX_SPATIAL: begin
                    next_readdata[15:0] = spatial_out;
                end
                `CGR_IDX_IND_ADDR: begin
                    next_readdata[15:0] = ind_addr;
                end
                `CGR_IDX_IND_DATA: begin
                    if (ind_hit) begin
                        next_readdata[15:0] = coef_out[ind_addr[3:0]];
                    end
                end
                `CGR_IDX_EQ_STAT: begin
                    next_readdata[15:0] = eq_flags;
                end
                default: begin
                    next_readdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase <= CGR_IDLE;
            readdata_out <= 32'h0000_0000;
            waitrequest_out <= 1'b1;
        end else begin
            phase <= next_phase;
            readdata_out <= next_readdata;
            waitrequest_out <= (next_phase != CGR_ANSWER);
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_a <= `CGR_SYNC_RST;
            sync_b <= `CGR_SYNC_RST;
        end else begin
            sync_a <= {reset_pen_pin_in, virtual_pin_source_in,
                       gpio_pin_in, thermal_in};
            sync_b <= sync_a;
        end
    end

    always_comb begin
        logic [15:0] sp_mask;
        sp_mask = `CGR_MASK_SPATIAL;
        next_pin_share = pin_share;
        next_drive = drive;
        next_misc = misc_out;
        next_spatial = spatial_out;
        next_ind_addr = ind_addr;
        next_coef = coef_out;
        if (spatial_out.spatial_enable) begin
            sp_mask = `CGR_MASK_SPATIAL & ~`CGR_MASK_SPATIAL_PARAM;
        end
        // overflow sets, write one clears, set wins
        next_eq_flags = eq_flags;
        if (commit && hit(address_in, `CGR_IDX_EQ_STAT)) begin
            next_eq_flags = eq_flags & ~(wdata & wmask);
        end
        next_eq_flags = (next_eq_flags | {11'h000, eq_overflow_in})
                        & `CGR_MASK_EQ_STAT;
        // write zero clears latch, new event wins
        next_latched = latched;
        if (commit && hit(address_in, `CGR_IDX_GPIO_STAT)) begin
            next_latched = latched & ~(~wdata & wmask);
        end
        next_latched = (next_latched
                        | (live & {2'b00, sticky_enable_in, 1'b0}))
                       & `CGR_MASK_GPIO_STAT;
        if (commit) begin
            case (address_in[8:2])
                `CGR_IDX_PIN_SHARE: begin
                    next_pin_share = merge(pin_share, wdata,
                                           wmask & `CGR_MASK_PIN_SHARE);
                end
                `CGR_IDX_DRIVE: begin
                    next_drive = merge(drive, wdata,
                                       wmask & `CGR_MASK_DRIVE);
                end
                `CGR_IDX_MISC: begin
                    next_misc = cgr_misc_s'(merge(misc_out, wdata,
                                                  wmask & `CGR_MASK_ALL));
                end
                `CGR_IDX_SPATIAL: begin
                    next_spatial = cgr_spatial_s'(merge(spatial_out, wdata,
                                                        wmask & sp_mask));
                end
                `CGR_IDX_IND_ADDR: begin
                    next_ind_addr = merge(ind_addr, wdata,
                                          wmask & `CGR_MASK_IND_ADDR);
                end
                // indexed write, locked by EQ enable
                `CGR_IDX_IND_DATA: begin
                    if (ind_hit && !eq_enable_in) begin
                        next_coef[ind_addr[3:0]] =
                            merge(coef_out[ind_addr[3:0]], wdata, wmask);
                    end
                end
                default: begin
                    next_pin_share = pin_share;
                end
            endcase
        end
        next_spatial_clear = !next_spatial.spatial_enable;
        next_allpass_reset = !next_spatial.allpass_enable;
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_share <= `CGR_RST_ZERO;
            drive <= `CGR_RST_ZERO;
            misc_out <= cgr_misc_s'(`CGR_RST_ZERO);
            spatial_out <= cgr_spatial_s'(`CGR_RST_SPATIAL);
            ind_addr <= `CGR_RST_ZERO;
            coef_out <= '0;
            eq_flags <= `CGR_RST_ZERO;
            latched <= `CGR_RST_ZERO;
            spatial_clear_out <= 1'b1;
            allpass_reset_out <= 1'b1;
        end else begin
            pin_share <= next_pin_share;
            drive <= next_drive;
            misc_out <= next_misc;
            spatial_out <= next_spatial;
            ind_addr <= next_ind_addr;
            coef_out <= next_coef;
            eq_flags <= next_eq_flags;
            latched <= next_latched;
            spatial_clear_out <= next_spatial_clear;
            allpass_reset_out <= next_allpass_reset;
        end
    end

    // Pin 2 doubles as the interrupt output when not shared to GPIO
    genvar g;
    generate
        for (g = 1; g <= 5; g++) begin : gpio_drv
            if (g == `CGR_PIN_SHARED) begin : shared
                assign next_pin_oe[g] = !pin_share[`CGR_BIT_PIN2_SEL] ||
                                        !pin_is_input_in[g];
                assign next_pin_out[g] = pin_share[`CGR_BIT_PIN2_SEL] ?
                                         drive[g] : irq_level;
            end else begin : plain
                assign next_pin_oe[g] = !pin_is_input_in[g];
                assign next_pin_out[g] = drive[g];
            end
        end
    endgenerate

    always_comb begin
        // reset input or pen down output
        next_rp_oe = misc_out.pendown_output_mode;
        next_rp_out = misc_out.pendown_output_mode && pen_status_in;
        // Pin is active low; ignored in pen down mode
        next_reset_req = !misc_out.pendown_output_mode &&
                         !sync_b[`CGR_SYNC_W-1];
        // status bit n to slot bit n plus four
        next_slot12 = {gpio_status, `CGR_SLOT_SHIFT};
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gpio_pin_out <= 5'h00;
            gpio_pin_oe_out <= 5'h00;
            reset_pen_pin_out <= 1'b0;
            reset_pen_pin_oe_out <= 1'b0;
            codec_reset_request_out <= 1'b0;
            slot12_status_out <= 20'h00000;
        end else begin
            gpio_pin_out <= next_pin_out;
            gpio_pin_oe_out <= next_pin_oe;
            reset_pen_pin_out <= next_rp_out;
            reset_pen_pin_oe_out <= next_rp_oe;
            codec_reset_request_out <= next_reset_req;
            slot12_status_out <= next_slot12;
        end
    end
endmodule

// ==== rtl/cgr_defs.svh ====
// Purpose: Offsets, masks, reset values and bit positions of the bank
// Assumes: Word index times four is the Avalon byte address
// Notes: Definitions only
`ifndef CGR_DEFS_SVH
`define CGR_DEFS_SVH
`define CGR_IDX_GPIO_STAT 7'h54
`define CGR_IDX_PIN_SHARE 7'h56
`define CGR_IDX_THERMAL 7'h58
`define CGR_IDX_DRIVE 7'h5C
`define CGR_IDX_MISC 7'h5E
`define CGR_IDX_SPATIAL 7'h68
`define CGR_IDX_IND_ADDR 7'h6A
`define CGR_IDX_IND_DATA 7'h6C
`define CGR_IDX_EQ_STAT 7'h6E
`define CGR_RST_ZERO 16'h0000
`define CGR_RST_SPATIAL 16'h0053
`define CGR_MASK_PIN_SHARE 16'h0004
`define CGR_MASK_DRIVE 16'h003E
`define CGR_MASK_SPATIAL 16'hF0F3
`define CGR_MASK_SPATIAL_PARAM 16'h00F0
`define CGR_MASK_IND_ADDR 16'h007F
`define CGR_MASK_EQ_STAT 16'h001F
`define CGR_MASK_GPIO_STAT 16'h2E3E
`define CGR_MASK_ALL 16'hFFFF
`define CGR_COEF_COUNT 7'h0D
`define CGR_SLOT_SHIFT 4'h0
`define CGR_SYNC_W 21
`define CGR_SYNC_RST 21'h11DCFF
`define CGR_BIT_PIN2_SEL 2
`define CGR_PIN_SHARED 2
`endif

// ==== rtl/cgr_pkg.sv ====
// Purpose: Types shared by the register bank and its neighbours
// Assumes: Nothing beyond the defs header
// Notes: Field order matches register bit order, msb first
package cgr_pkg;
    typedef enum logic {CGR_IDLE = 1'b0, CGR_ANSWER = 1'b1} cgr_phase_e;
    typedef struct packed {
        logic fast_ref_disable;
        logic weak_amp_select;
        logic [1:0] auto_volume_target;
        logic thermal_shutdown_enable;
        logic pendown_output_mode;
        logic [2:0] spare_hi;
        logic dac_left_mute;
        logic dac_right_mute;
        logic [2:0] spare_lo;
        logic wakeup_enable;
        logic irq_invert;
    } cgr_misc_s;
    typedef struct packed {
        logic spatial_enable;
        logic allpass_enable;
        logic pseudo_stereo_enable;
        logic stereo_widen_enable;
        logic [3:0] spare_a;
        logic [1:0] widen_gain_param;
        logic [1:0] widen_ratio_param;
        logic [1:0] spare_b;
        logic [1:0] allpass_rate_select;
    } cgr_spatial_s;
    typedef struct packed {
        logic headphone_amp_overheat;
        logic mono_amp_overheat;
        logic bias1_overcurrent;
        logic bias2_overcurrent;
        logic [3:0] depop_done;
        logic [3:0] sensor_overheat;
    } cgr_thermal_s;
    typedef struct packed {
        logic overtemp;
        logic mic_bias_supply_one_short;
        logic mic_bias_supply_two_short;
    } cgr_virtual_s;
    typedef logic [12:0][15:0] cgr_coef_t;
endpackage

// ==== testbench/cgr_regbank_checker.sv ====
// Purpose: Bus and output checks for the register bank
// Assumes: One wait state per access
// Notes: Sees only the bank ports
`timescale 1ns/1ps
module cgr_regbank_checker
    import cgr_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [8:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    input wire logic [31:0] readdata_out,
    input wire logic waitrequest_out,
    input wire logic eq_enable_in,
    input wire logic [19:0] slot12_status_out,
    input wire cgr_pkg::cgr_misc_s misc_out,
    input wire cgr_pkg::cgr_spatial_s spatial_out,
    input wire logic reset_pen_pin_oe_out,
    input wire cgr_pkg::cgr_coef_t coef_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    logic wr_done;
    assign wr_done = write_in && !waitrequest_out;
    a_wait_one: assert property (
        (read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("no answer after one wait cycle");
    a_wait_short: assert property (!waitrequest_out |=> waitrequest_out)
        else $error("wait low for more than one cycle");
    a_read_upper: assert property (readdata_out[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    // Unused slot bits must stay low
    a_slot_unused: assert property (
        (slot12_status_out & 20'hD1C1F) == 20'h00000)
        else $error("unused slot bit set");
    a_misc_write: assert property (
        wr_done && address_in[8:2] == 7'h5E && byteenable_in[1:0] == 2'h3
        |=> misc_out == $past(writedata_in[15:0]))
        else $error("misc write not stored");
    a_widen_lock: assert property (
        wr_done && address_in[8:2] == 7'h68 && spatial_out.spatial_enable
        |=> $stable(spatial_out[7:4]))
        else $error("widen field changed while enabled");
    a_coef_lock: assert property (eq_enable_in |=> $stable(coef_out))
        else $error("coefficient changed while locked");
    a_pen_drive: assert property (
        $stable(misc_out.pendown_output_mode)
        |-> reset_pen_pin_oe_out == misc_out.pendown_output_mode)
        else $error("shared pin enable wrong");
endmodule
bind cgr_regbank cgr_regbank_checker i_cgr_regbank_checker (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .eq_enable_in(eq_enable_in),
    .slot12_status_out(slot12_status_out), .misc_out(misc_out),
    .spatial_out(spatial_out), .reset_pen_pin_oe_out(reset_pen_pin_oe_out),
    .coef_out(coef_out)
);

// ==== testbench/cgr_link_host.sv ====
// Purpose: Link controller side of the shared reset and pen pin
// Assumes: Pin pulled up when nobody drives it
// Notes: Keeps the first pen event only
`timescale 1ns/1ps
module cgr_link_host (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic hold_reset_in,
    input wire logic dev_oe_in,
    input wire logic dev_out_in,
    output logic pin_level_out,
    output logic pen_seen_out
);
    logic host_oe;
    assign host_oe = hold_reset_in && !dev_oe_in;
    assign pin_level_out = dev_oe_in ? dev_out_in : !host_oe;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pen_seen_out <= 1'b0;
        end else if (dev_oe_in && dev_out_in) begin
            pen_seen_out <= 1'b1;
        end
    end
endmodule

// ==== testbench/codec_gpio_effects_regbank_bench.sv ====
// Purpose: Self-checking bench for the register bank
// Assumes: Fixed seed, one request at a time
// Notes: Pins resolved from all drivers
`timescale 1ns/1ps
module codec_gpio_effects_regbank_bench;
    import cgr_pkg::*;
    logic clock_in, reset_n_in, read_in, write_in, waitrequest_out;
    logic pen, irq, eq_en, hold_rst, rp_in, rp_out, rp_oe, rst_req;
    logic pen_seen, sp_clr, apf_rst;
    logic [8:0] address_in;
    logic [31:0] writedata_in, readdata_out, rd;
    logic [3:0] byteenable_in;
    logic [1:0] b;
    logic [4:0] eq_ovf;
    logic [13:1] sticky;
    logic [5:1] pin_cfg, pin_drv, pin_wire, pin_out, pin_oe;
    logic [19:0] slot12;
    logic [15:0] v, exp_misc, coef_ref [13];
    logic [6:0] zidx [6] = '{7'h56, 7'h5C, 7'h5E, 7'h6A, 7'h6C, 7'h6E};
    cgr_thermal_s thermal;
    cgr_virtual_s virt;
    cgr_misc_s misc;
    cgr_spatial_s spatial;
    cgr_coef_t coef;
    int num_errors = 0;
    int cmp_count = 0;
    // Undriven pin would read as unknown
    assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_drv);
    cgr_regbank i_cgr_regbank (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
        .byteenable_in(byteenable_in), .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out), .thermal_in(thermal),
        .virtual_pin_source_in(virt), .pen_status_in(pen),
        .sticky_enable_in(sticky), .pin_is_input_in(pin_cfg),
        .irq_request_in(irq), .eq_enable_in(eq_en), .eq_overflow_in(eq_ovf),
        .gpio_pin_in(pin_wire), .gpio_pin_out(pin_out),
        .gpio_pin_oe_out(pin_oe), .reset_pen_pin_in(rp_in),
        .reset_pen_pin_out(rp_out), .reset_pen_pin_oe_out(rp_oe),
        .codec_reset_request_out(rst_req), .slot12_status_out(slot12),
        .misc_out(misc), .spatial_out(spatial), .spatial_clear_out(sp_clr),
        .allpass_reset_out(apf_rst), .coef_out(coef)
    );
    cgr_link_host i_cgr_link_host (
        .clock_in(clock_in), .reset_n_in(reset_n_in),
        .hold_reset_in(hold_rst), .dev_oe_in(rp_oe), .dev_out_in(rp_out),
        .pin_level_out(rp_in), .pen_seen_out(pen_seen)
    );
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    task automatic check(input string name, input logic [31:0] e,
                         input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [6:0] idx,
                       input logic [15:0] d, input logic [1:0] be = 2'h3);
        @(posedge clock_in);
        address_in <= {idx, 2'h0};
        writedata_in <= {16'h0000, d};
        byteenable_in <= {2'h0, be};
        read_in <= !wr;
        write_in <= wr;
        // Only the watchdog ends a stalled wait
        do begin
            @(posedge clock_in);
        end while (waitrequest_out !== 1'b0);
        rd = readdata_out;
        read_in <= 1'b0;
        write_in <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [6:0] idx,
                         input logic [15:0] e);
        bus(1'b0, idx, 16'h0000);
        check(name, {16'h0000, e}, rd);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        @(negedge clock_in);
    endtask
    function automatic logic [15:0] merge(input logic [15:0] o, n,
                                          input logic [1:0] be);
        return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
    endfunction
    task automatic end_sim();
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Whole run needs far fewer cycles than this
    initial begin
        #1000000;
        num_errors++;
        end_sim();
    end
    initial begin
        {reset_n_in, read_in, write_in, pen, irq, eq_en, hold_rst} = '0;
        {address_in, writedata_in, byteenable_in, eq_ovf, sticky} = '0;
        {thermal, virt, pin_drv} = '0;
        pin_cfg = 5'h1F;
        void'($urandom(32'hD9C1D670));
        repeat (12) @(posedge clock_in);
        reset_n_in <= 1'b1;
        bus(1'b1, 7'h60, 16'hFFFF);
        rdchk("unmapped", 7'h60, 16'h0000);
        for (int i = 0; i < 6; i++) rdchk("reset", zidx[i], 16'h0000);
        rdchk("spatial reset", 7'h68, 16'h0053);
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom()) & 16'h0FFF;
            @(posedge clock_in);
            thermal <= v[11:0];
            tick(3);
            bus(1'b1, 7'h58, ~v);
            rdchk("thermal flags", 7'h58, v);
        end
        exp_misc = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            v = (16'($urandom()) & 16'hCFFF) | 16'(i % 4) << 12;
            b = i < 4 ? 2'h3 : 2'($urandom());
            bus(1'b1, 7'h5E, v, b);
            exp_misc = merge(exp_misc, v, b);
            rdchk("misc", 7'h5E, exp_misc);
            check("avc", 32'(exp_misc[13:12]), 32'(misc[13:12]));
        end
        for (int i = 0; i < 4; i++) begin
            v = (16'($urandom()) & 16'h7FF0) | 16'(i);
            bus(1'b1, 7'h68, v);
            rdchk("spatial", 7'h68, v & 16'hF0F3);
            tick(1);
            check("allpass reset", 32'(!v[14]), 32'(apf_rst));
            check("spatial clear", 32'h1, 32'(sp_clr));
        end
        bus(1'b1, 7'h68, 16'h9050);
        bus(1'b1, 7'h68, 16'h80A3);
        rdchk("widen lock", 7'h68, 16'h8053);
        tick(1);
        check("spatial clear", 32'h0, 32'(sp_clr));
        bus(1'b1, 7'h68, 16'h0000);
        rdchk("spatial off", 7'h68, 16'h0050);
        bus(1'b1, 7'h6A, 16'hFFFF);
        rdchk("index address", 7'h6A, 16'h007F);
        for (int i = 0; i < 13; i++) begin
            coef_ref[i] = 16'($urandom());
            bus(1'b1, 7'h6A, 16'(i));
            bus(1'b1, 7'h6C, coef_ref[i]);
        end
        for (int i = 12; i >= 0; i--) begin
            bus(1'b1, 7'h6A, 16'(i));
            rdchk("index data", 7'h6C, coef_ref[i]);
            check("coef", 32'(coef_ref[i]), 32'(coef[i]));
        end
        @(posedge clock_in);
        eq_en <= 1'b1;
        bus(1'b1, 7'h6C, ~coef_ref[0]);
        rdchk("eq lock", 7'h6C, coef_ref[0]);
        @(posedge clock_in);
        eq_en <= 1'b0;
        bus(1'b1, 7'h6A, 16'h000D);
        bus(1'b1, 7'h6C, 16'hFFFF);
        rdchk("index beyond", 7'h6C, 16'h0000);
        @(posedge clock_in);
        eq_ovf <= 5'h1F;
        @(posedge clock_in);
        eq_ovf <= 5'h00;
        rdchk("eq flags", 7'h6E, 16'h001F);
        bus(1'b1, 7'h6E, 16'hFFEB);
        rdchk("eq flags w1c", 7'h6E, 16'h0014);
        // Overflow on the clearing edge must win
        @(posedge clock_in);
        eq_ovf <= 5'h10;
        bus(1'b1, 7'h6E, 16'h0010);
        eq_ovf <= 5'h00;
        rdchk("eq set wins", 7'h6E, 16'h0014);
        @(posedge clock_in);
        pin_cfg <= 5'h00;
        bus(1'b1, 7'h56, 16'hFFFF);
        rdchk("pin share", 7'h56, 16'h0004);
        v = 16'($urandom()) & 16'h003E;
        bus(1'b1, 7'h5C, v | 16'hFFC1);
        rdchk("pin drive", 7'h5C, v);
        tick(2);
        check("pin levels", 32'(v[5:1]), 32'(pin_out));
        check("pin enables", 32'h1F, 32'(pin_oe));
        bus(1'b1, 7'h56, 16'h0000);
        bus(1'b1, 7'h5E, 16'h0001);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock_in);
            irq <= i[0];
            tick(3);
            check("irq pin", 32'(!i[0]), 32'(pin_out[2]));
            check("irq enable", 32'h1, 32'(pin_oe[2]));
        end
        @(posedge clock_in);
        pin_cfg <= 5'h1F;
        bus(1'b1, 7'h56, 16'h0004);
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom()) & 16'h2E3E;
            @(posedge clock_in);
            pin_drv <= v[5:1];
            virt <= v[11:9];
            pen <= v[13];
            tick(4);
            check("slot12", {12'h000, v, 4'h0}, {12'h000, slot12});
            rdchk("pin status", 7'h54, v);
        end
        @(posedge clock_in);
        {virt, pen} <= '0;
        sticky <= 13'h0001;
        pin_drv <= 5'h01;
        tick(4);
        @(posedge clock_in);
        pin_drv <= 5'h00;
        tick(4);
        rdchk("sticky held", 7'h54, 16'h0002);
        bus(1'b1, 7'h54, 16'h0000);
        rdchk("sticky cleared", 7'h54, 16'h0000);
        @(posedge clock_in);
        hold_rst <= 1'b1;
        tick(5);
        check("reset request", 32'h1, 32'(rst_req));
        @(posedge clock_in);
        hold_rst <= 1'b0;
        tick(5);
        check("reset release", 32'h0, 32'(rst_req));
        @(posedge clock_in);
        pen <= 1'b1;
        bus(1'b1, 7'h5E, 16'h0400);
        tick(2);
        check("pen pin", 32'h3, 32'({rp_oe, rp_out}));
        check("host pen", 32'h1, 32'(pen_seen));
        end_sim();
    end
endmodule
